//--- acr_config.sv
// How it works
// R1 - Divider field sets conversion clock ratio minus one
// R2 - Software keeps divider nonzero under memory power control
// R3 - Bit 2 picks right or left result alignment
// R4 - Alignment ignored while eight-bit mode is on
// R5 - Bit 1 picks ten-bit or eight-bit conversion
// R6 - Bit 0 picks gain one half or one
// R7 - Reset loads configuration value 0xF9
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs.svh"

module acr_config (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire acr_pkg::acr_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // Converter side
    input wire logic [9:0] conv_result,
    input wire logic conv_done,
    input wire logic memory_power_ctrl_enable,
    output logic conversion_clock,
    output logic eight_bit_mode_enable,
    output logic input_gain_select,
    output logic divider_guard_error
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    acr_pkg::acr_cfg_t cfg_q, cfg_d;
    acr_pkg::acr_result_t res_q, res_d;
    logic [4:0] div_cnt_q, div_cnt_d;
    logic tick_q, tick_d;
    logic mode_q, mode_d;
    logic gain_q, gain_d;
    logic guard_q, guard_d;
    logic [7:0] rdata_q, rdata_d;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    function automatic acr_pkg::acr_result_t format_result(
        input logic [9:0] raw,
        input logic left,
        input logic eight
    );
        acr_pkg::acr_result_t r;
        r = '0;
        if (eight) begin
            // Eight-bit result keeps the top bits, justification is moot
            r.result_high_byte = 8'h00; // [R4]
            r.result_low_byte = raw[9:2]; // [R5]
        end else if (left) begin
            r.result_high_byte = raw[9:2]; // [R3]
            r.result_low_byte = {raw[1:0], 6'b00_0000};
        end else begin
            r.result_high_byte = {6'b00_0000, raw[9:8]}; // [R3]
            r.result_low_byte = raw[7:0];
        end
        format_result = r;
    endfunction

    // ----------------------------------------
    // Configuration and result registers
    // ----------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        res_d = res_q;
        if (bus_req.wr && hit(bus_req.addr, `ACR_OFF_CONFIG)) begin
            cfg_d = acr_pkg::acr_cfg_t'(bus_req.wdata); // [R1] [R3] [R5] [R6]
        end
        if (conv_done) begin
            // Format with the settings in force at completion
            res_d = format_result(conv_result, cfg_q.left_align_select,
                                  cfg_q.eight_bit_mode_enable); // [R3] [R4]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_q <= acr_pkg::acr_cfg_t'(`ACR_CONFIG_RESET); // [R7]
            res_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            res_q <= res_d;
        end
    end

    // ----------------------------------------
    // Conversion clock divider
    // ----------------------------------------
    // A one-cycle tick every divider+1 system clocks; a value of zero
    // ticks every cycle. Lowering the divider mid-count ends the period
    // at once instead of wrapping through 31.
    always_comb begin
        div_cnt_d = div_cnt_q + 5'h01;
        tick_d = 1'b0;
        if (div_cnt_q >= cfg_q.conv_clock_divider) begin
            div_cnt_d = 5'h00; // [R1]
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_cnt_q <= 5'h00;
            tick_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------
    // Converter control outputs and status
    // ----------------------------------------
    always_comb begin
        mode_d = cfg_q.eight_bit_mode_enable; // [R5]
        gain_d = cfg_q.input_gain_select; // [R6]
        // Flags a divider below the minimum while memory power control is on
        guard_d = memory_power_ctrl_enable
            && (cfg_q.conv_clock_divider < `ACR_DIV_MIN); // [R2]
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= 1'b0;
            gain_q <= 1'b1;
            guard_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            gain_q <= gain_d;
            guard_q <= guard_d;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            if (hit(bus_req.addr, `ACR_OFF_CONFIG)) begin
                rdata_d = cfg_q;
            end else if (hit(bus_req.addr, `ACR_OFF_RESULT_HIGH)) begin
                rdata_d = res_q.result_high_byte;
            end else if (hit(bus_req.addr, `ACR_OFF_RESULT_LOW)) begin
                rdata_d = res_q.result_low_byte;
            end else if (hit(bus_req.addr, `ACR_OFF_STATUS)) begin
                rdata_d = {7'b000_0000, guard_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rd_data = rdata_q;
    assign conversion_clock = tick_q;
    assign eight_bit_mode_enable = mode_q;
    assign input_gain_select = gain_q;
    assign divider_guard_error = guard_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Cycles since the last tick, and whether the whole configuration byte held meanwhile
    logic [5:0] gap_q;
    logic div_stable_q;
    logic seen_tick_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gap_q <= 6'h00;
            div_stable_q <= 1'b0;
            seen_tick_q <= 1'b0;
        end else if (tick_q) begin
            gap_q <= 6'h01;
            div_stable_q <= 1'b1;
            seen_tick_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 6'h01;
            if (cfg_d != cfg_q) begin
                div_stable_q <= 1'b0;
            end
        end
    end

    a_reset_config_value: assert property ( // [R7]
        @(posedge ref_clk) disable iff (1'b0)
        reset |=> (cfg_q == `ACR_CONFIG_RESET) && gain_q && !mode_q)
        else $error("Configuration not 0xF9 after reset");

    a_tick_period_ratio: assert property ( // [R1]
        tick_q && seen_tick_q && div_stable_q && $stable(cfg_q)
        |-> gap_q == ({1'b0, cfg_q.conv_clock_divider} + 6'h01))
        else $error("Conversion tick spacing not divider plus one");

    a_config_write_lands: assert property ( // [R1]
        bus_req.wr && hit(bus_req.addr, `ACR_OFF_CONFIG)
        |=> cfg_q == $past(bus_req.wdata))
        else $error("Configuration write not stored");

    a_right_align_result: assert property ( // [R3]
        conv_done && !cfg_q.eight_bit_mode_enable && !cfg_q.left_align_select
        |=> res_q.result_high_byte == {6'b00_0000, $past(conv_result[9:8])}
            && res_q.result_low_byte == $past(conv_result[7:0]))
        else $error("Right-justified result misplaced");

    a_left_align_result: assert property ( // [R3]
        conv_done && !cfg_q.eight_bit_mode_enable && cfg_q.left_align_select
        |=> res_q.result_high_byte == $past(conv_result[9:2])
            && res_q.result_low_byte[7:6] == $past(conv_result[1:0])
            && res_q.result_low_byte[5:0] == 6'h00)
        else $error("Left-justified result misplaced");

    a_eight_bit_ignores: assert property ( // [R4]
        conv_done && cfg_q.eight_bit_mode_enable
        |=> res_q.result_low_byte == $past(conv_result[9:2])
            && res_q.result_high_byte == 8'h00)
        else $error("Alignment select honoured in eight-bit mode");

    a_mode_output_follows: assert property ( // [R5]
        $changed(cfg_q.eight_bit_mode_enable)
        |=> eight_bit_mode_enable == $past(cfg_q.eight_bit_mode_enable))
        else $error("Resolution output lags configuration");

    a_gain_output_follows: assert property ( // [R6]
        bus_req.wr && hit(bus_req.addr, `ACR_OFF_CONFIG)
        |=> ##1 input_gain_select == $past(bus_req.wdata[`ACR_GAIN_BIT], 2))
        else $error("Gain output does not follow bit 0");

    a_divider_guard_flag: assert property ( // [R2]
        memory_power_ctrl_enable && cfg_q.conv_clock_divider == 5'h00
        |=> divider_guard_error)
        else $error("Zero divider under memory power control not flagged");

    a_divider_guard_clear: assert property ( // [R2]
        !(memory_power_ctrl_enable && cfg_q.conv_clock_divider == 5'h00)
        |=> !divider_guard_error)
        else $error("Guard raised without a zero divider under power control");

    a_tick_gap_bound: assert property ( // [R1]
        !tick_q && seen_tick_q && div_stable_q
        |-> gap_q <= {1'b0, cfg_q.conv_clock_divider})
        else $error("Conversion tick later than divider plus one");

    // Read path returns what the registers held at the strobe
    a_guard_status_read: assert property ( // [R2]
        bus_req.rd && hit(bus_req.addr, `ACR_OFF_STATUS)
        |=> rd_data == {7'h00, $past(guard_q)})
        else $error("Status read does not show the guard flag");

    a_config_read_back: assert property ( // [R1]
        bus_req.rd && hit(bus_req.addr, `ACR_OFF_CONFIG)
        |=> rd_data == $past(cfg_q))
        else $error("Configuration read does not return the stored byte");

    a_other_write_ignored: assert property ( // [R1]
        bus_req.wr && !hit(bus_req.addr, `ACR_OFF_CONFIG)
        |=> cfg_q == $past(cfg_q))
        else $error("Write to another address changed the configuration");

    a_high_byte_read: assert property ( // [R3]
        bus_req.rd && hit(bus_req.addr, `ACR_OFF_RESULT_HIGH)
        |=> rd_data == $past(res_q.result_high_byte))
        else $error("High result read does not return the stored byte");

    a_low_byte_read: assert property ( // [R3]
        bus_req.rd && hit(bus_req.addr, `ACR_OFF_RESULT_LOW)
        |=> rd_data == $past(res_q.result_low_byte))
        else $error("Low result read does not return the stored byte");

    a_mode_output_lag: assert property ( // [R5]
        !$past(reset)
        |-> eight_bit_mode_enable == $past(cfg_q.eight_bit_mode_enable))
        else $error("Resolution output not one cycle behind configuration");

    a_gain_output_lag: assert property ( // [R6]
        !$past(reset)
        |-> input_gain_select == $past(cfg_q.input_gain_select))
        else $error("Gain output not one cycle behind configuration");

    c_left_aligned: cover property (
        conv_done && cfg_q.left_align_select && !cfg_q.eight_bit_mode_enable);
    c_eight_bit_result: cover property (conv_done && cfg_q.eight_bit_mode_enable);
    c_right_aligned: cover property (
        conv_done && !cfg_q.left_align_select && !cfg_q.eight_bit_mode_enable);
    c_fastest_clock: cover property (tick_q && cfg_q.conv_clock_divider == 5'h00 ##1 tick_q);
    c_guard_raised: cover property (divider_guard_error);

endmodule // acr_config

`default_nettype wire

//--- acr_regs.svh
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACR_ADDR_W 8
`define ACR_OFF_CONFIG 8'h00
`define ACR_OFF_RESULT_HIGH 8'h01
`define ACR_OFF_RESULT_LOW 8'h02
`define ACR_OFF_STATUS 8'h03

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define ACR_DIV_MSB 7
`define ACR_DIV_LSB 3
`define ACR_DIV_W 5
`define ACR_LEFT_BIT 2
`define ACR_EIGHT_BIT 1
`define ACR_GAIN_BIT 0
`define ACR_STAT_GUARD_BIT 0
`define ACR_RESULT_W 10

// ----------------------------------------
// Reset value and divider minimum
// ----------------------------------------
`define ACR_CONFIG_RESET 8'hF9
`define ACR_DIV_MIN 5'h01

`endif

//--- acr_pkg.sv
package acr_pkg;

    // Register bus request, one cycle per strobe
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acr_bus_req_t;

    // Configuration byte, laid out as the register itself
    typedef struct packed {
        logic [4:0] conv_clock_divider;
        logic left_align_select;
        logic eight_bit_mode_enable;
        logic input_gain_select;
    } acr_cfg_t;

    // Formatted result byte pair
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } acr_result_t;

endpackage

//--- tb_acr_config.sv
`timescale 1ns/1ps
`default_nettype none

module tb_acr_config;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic ref_clk;
    logic reset;
    acr_pkg::acr_bus_req_t bus_req;
    logic [7:0] rd_data;
    logic [9:0] conv_result;
    logic conv_done;
    logic memory_power_ctrl_enable;
    logic conversion_clock;
    logic eight_bit_mode_enable;
    logic input_gain_select;
    logic divider_guard_error;
    int n_mismatch;
    int check_count;
    logic [7:0] rdv;
    // Row: config byte, raw result, expected high byte, expected low byte
    logic [33:0] rows [5] = '{
        {8'hF9, 10'h2A5, 8'h02, 8'hA5},
        {8'h05, 10'h2A5, 8'hA9, 8'h40},
        {8'h06, 10'h2A5, 8'h00, 8'hA9},
        {8'h02, 10'h3FF, 8'h00, 8'hFF},
        {8'h00, 10'h3FF, 8'h03, 8'hFF}
    };

    acr_config u_acr_config (
        .ref_clk(ref_clk),
        .reset(reset),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .conv_result(conv_result),
        .conv_done(conv_done),
        .memory_power_ctrl_enable(memory_power_ctrl_enable),
        .conversion_clock(conversion_clock),
        .eight_bit_mode_enable(eight_bit_mode_enable),
        .input_gain_select(input_gain_select),
        .divider_guard_error(divider_guard_error)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Bench tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        d = rd_data;
    endtask

    task automatic convert(input logic [9:0] r);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        conv_result <= ~r;
    endtask

    // First tick only resynchronises; a shortened period may precede it
    task automatic period(input int exp);
        int n;
        int k;
        n = 0;
        k = 0;
        while (conversion_clock !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (conversion_clock !== 1'b1 && n < 40);
        if (k >= 40 || n >= 40) begin
            n_mismatch++;
            results();
        end else begin
            chk(8'(n), 8'(exp));
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        check_count = 0;
        reset = 1'b1;
        bus_req = '0;
        conv_result = 10'h000;
        conv_done = 1'b0;
        memory_power_ctrl_enable = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({5'h00, divider_guard_error, eight_bit_mode_enable, input_gain_select}, 8'h01);
        bus_rd(8'h00, rdv);
        chk(rdv, 8'hF9);
        period(32);
        foreach (rows[i]) begin
            bus_wr(8'h00, rows[i][33:26]);
            bus_rd(8'h00, rdv);
            chk(rdv, rows[i][33:26]);
            chk({6'h00, eight_bit_mode_enable, input_gain_select}, {6'h00, rows[i][27:26]});
            convert(rows[i][25:16]);
            bus_rd(8'h01, rdv);
            chk(rdv, rows[i][15:8]);
            bus_rd(8'h02, rdv);
            chk(rdv, rows[i][7:0]);
        end
        // Result registers are read-only; a write must not disturb them
        bus_wr(8'h01, 8'h5A);
        bus_rd(8'h01, rdv);
        chk(rdv, 8'h03);
        bus_rd(8'h10, rdv);
        chk(rdv, 8'h00);
        period(1);
        bus_wr(8'h00, 8'h18);
        period(4);
        // Guard flags a zero divider under memory power control and clears once the divider is one
        bus_wr(8'h00, 8'h00);
        memory_power_ctrl_enable <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h00, divider_guard_error}, 8'h01);
        bus_rd(8'h03, rdv);
        chk({7'h00, rdv[0]}, 8'h01);
        bus_wr(8'h00, 8'h08);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h00, divider_guard_error}, 8'h00);
        // Reset in mid-run restores the default byte
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        bus_rd(8'h00, rdv);
        chk(rdv, 8'hF9);
        chk({5'h00, divider_guard_error, eight_bit_mode_enable, input_gain_select}, 8'h01);
        results();
    end

endmodule // tb_acr_config

`default_nettype wire
